/* inc/gpsms_defs.svh */
`ifndef GPSMS_DEFS_SVH
`define GPSMS_DEFS_SVH
`define GPSMS_OFF_PIN_LEVEL_DATA      12'h340
`define GPSMS_OFF_SERIAL_MGMT_STATUS  12'h344
`define GPSMS_OFF_IRQ_MASK            12'h350
`define GPSMS_OFF_PIN_ALTERNATE       12'h338
`define GPSMS_OFF_PIN_DIRECTION       12'h33C
`define GPSMS_PIN_COUNT               16
`define GPSMS_SLAVE_ADDR_LSB          1
`define GPSMS_MASTER_ADDR_LSB         9
`define GPSMS_LOAD_DONE_BIT           24
`define GPSMS_NO_ACK_BIT              25
`define GPSMS_LOST_ARB_BIT            26
`define GPSMS_MISPLACED_BIT           27
`define GPSMS_CHECKSUM_BIT            28
`define GPSMS_UNMAPPED_BIT            29
`define GPSMS_ARB_LIMIT               5'h10
`define GPSMS_PIN_LEVEL_RESET         16'h0000
`define GPSMS_ERROR_RESET             5'h00
`define GPSMS_MASK_RESET              6'h00
`endif

/* inc/gpsms_pkg.sv */
package gpsms_pkg;
  typedef enum logic [1:0] {
    GPSMS_ARB_IDLE  = 2'b00,
    GPSMS_ARB_RETRY = 2'b01
  } gpsms_arb_state_type;
endpackage

/* hw/gpsms_regs.sv */
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`include "gpsms_defs.svh"

// Function
// R01: Data bit n maps to pin n.
// R02: Data read returns sampled pin levels always.
// R03: Data write drives only ordinary output pins.
// R04: Status bits 7:1 show slave address.
// R05: Status bits 15:9 show master address.
// R06: Load-complete bit set at EEPROM finish/error.
// R07: Unexpected NACK sets W1C no-ack flag.
// R08: Lost arbitration retries automatically.
// R09: Sixteen consecutive losses abort, set flag.
// R10: Misplaced START/STOP sets W1C flag.
// R11: Bad EEPROM checksum sets checksum flag.
// R12: Missing done command sets checksum flag.
// R13: Unmapped register load sets W1C flag.
// R14: Output only when alternate clear, direction set.
// R15: Reserved bits read zero, ignore writes.
module gpsms_regs
  import gpsms_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] pin_in,
  output logic      [15:0] pin_out,
  output logic      [15:0] pin_oe,
  input  wire logic [6:0]  slave_bus_address,
  input  wire logic [6:0]  master_bus_address,
  input  wire logic        boot_load_enable,
  input  wire logic        boot_load_finish,
  input  wire logic        ev_no_ack,
  input  wire logic        ev_arb_lost,
  input  wire logic        ev_arb_won,
  input  wire logic        ev_misplaced,
  input  wire logic        ev_checksum_bad,
  input  wire logic        ev_no_done_cmd,
  input  wire logic        ev_unmapped,
  output logic             arb_retry,
  output logic             arb_abort,
  output logic             irq
);
  localparam int N = `GPSMS_PIN_COUNT;

  // Pin levels come from outside, so two flops precede any reader.
  logic [N-1:0] pin_sync1;
  logic [N-1:0] pin_sync2;
  logic [N-1:0] pin_level_field;
  logic [N-1:0] pin_alternate_select;
  logic [N-1:0] pin_direction_select;
  logic [N-1:0] next_pin_level_field;
  logic [N-1:0] next_pin_alternate_select;
  logic [N-1:0] next_pin_direction_select;
  logic [N-1:0] pin_out_q;
  logic [N-1:0] pin_oe_q;
  logic [N-1:0] next_pin_out;
  logic [N-1:0] next_pin_oe;
  logic         boot_load_complete;
  logic         next_boot_load_complete;
  logic [4:0]   err;
  logic [4:0]   next_err;
  logic [5:0]   irq_mask;
  logic [5:0]   next_irq_mask;
  logic [31:0]  next_prdata;
  logic         next_pready;
  logic         next_pslverr;
  logic         next_irq;
  gpsms_arb_state_type arb_state;
  gpsms_arb_state_type next_arb_state;
  logic [4:0]   arb_count;
  logic [4:0]   next_arb_count;
  logic         next_arb_retry;
  logic         next_arb_abort;
  logic [4:0]   ev_vec;
  logic         wr;
  logic         rd;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [31:0] status_word(input logic [6:0] sa, input logic [6:0] ma,
                                              input logic done, input logic [4:0] e);
    status_word = 32'h0000_0000;
    status_word[`GPSMS_SLAVE_ADDR_LSB +: 7] = sa;  // [R04] [R15]
    status_word[`GPSMS_MASTER_ADDR_LSB +: 7] = ma; // [R05]
    status_word[`GPSMS_LOAD_DONE_BIT] = done;
    status_word[`GPSMS_NO_ACK_BIT +: 5] = e;
  endfunction

  // True for every offset that this bank decodes; anything else is refused.
  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, `GPSMS_OFF_PIN_LEVEL_DATA) ||
             hit(a, `GPSMS_OFF_SERIAL_MGMT_STATUS) ||
             hit(a, `GPSMS_OFF_IRQ_MASK) ||
             hit(a, `GPSMS_OFF_PIN_ALTERNATE) ||
             hit(a, `GPSMS_OFF_PIN_DIRECTION);
  endfunction

  assign wr = psel & penable & pwrite & pready;
  assign rd = psel & ~penable & ~pwrite;
  assign ev_vec = {ev_unmapped,                     // [R13]
                   ev_checksum_bad | ev_no_done_cmd, // [R11] [R12]
                   ev_misplaced,                    // [R10]
                   arb_abort,                       // [R09]
                   ev_no_ack};                      // [R07]

  always_comb begin
    next_pin_level_field      = pin_level_field;
    next_pin_alternate_select = pin_alternate_select;
    next_pin_direction_select = pin_direction_select;
    next_irq_mask             = irq_mask;
    next_boot_load_complete   = boot_load_complete;
    next_err                  = err | ev_vec;
    // A load that stops on an error has still finished, so the done bit follows.
    if (boot_load_enable && (boot_load_finish || ev_checksum_bad || ev_no_done_cmd ||
                             ev_unmapped)) begin
      next_boot_load_complete = 1'b1; // [R06]
    end
    if (wr) begin
      if (hit(paddr, `GPSMS_OFF_PIN_LEVEL_DATA)) begin
        next_pin_level_field = pwdata[N-1:0]; // [R03] [R15]
      end
      if (hit(paddr, `GPSMS_OFF_SERIAL_MGMT_STATUS)) begin
        // Set wins over clear: a fresh event survives a same-cycle W1C.
        next_err = (err & ~pwdata[`GPSMS_NO_ACK_BIT +: 5]) | ev_vec; // [R07]
      end
      if (hit(paddr, `GPSMS_OFF_IRQ_MASK)) begin
        // Mask bits sit where the status bits they gate sit.
        next_irq_mask = pwdata[`GPSMS_LOAD_DONE_BIT +: 6];
      end
      if (hit(paddr, `GPSMS_OFF_PIN_ALTERNATE)) begin
        next_pin_alternate_select = pwdata[N-1:0];
      end
      if (hit(paddr, `GPSMS_OFF_PIN_DIRECTION)) begin
        next_pin_direction_select = pwdata[N-1:0];
      end
    end
  end

  // Pin drivers are registered so each pad sees a glitch-free enable.
  generate
    for (genvar i = 0; i < N; i++) begin : g_pin
      always_comb begin
        next_pin_oe[i]  = ~next_pin_alternate_select[i] & next_pin_direction_select[i]; // [R14]
        next_pin_out[i] = next_pin_oe[i] & next_pin_level_field[i]; // [R01] [R03]
      end
    end
  endgenerate

  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    if (rd) begin
      if (hit(paddr, `GPSMS_OFF_PIN_LEVEL_DATA)) begin
        next_prdata = {16'h0000, pin_sync2}; // [R02] [R01] [R15]
      end else if (hit(paddr, `GPSMS_OFF_SERIAL_MGMT_STATUS)) begin
        next_prdata = status_word(slave_bus_address, master_bus_address,
                                  boot_load_complete, err);
      end else if (hit(paddr, `GPSMS_OFF_IRQ_MASK)) begin
        next_prdata = {2'h0, irq_mask, 24'h000000};
      end else if (hit(paddr, `GPSMS_OFF_PIN_ALTERNATE)) begin
        next_prdata = {16'h0000, pin_alternate_select};
      end else if (hit(paddr, `GPSMS_OFF_PIN_DIRECTION)) begin
        next_prdata = {16'h0000, pin_direction_select};
      end else begin
        next_pslverr = 1'b1;
      end
    end else if (psel && penable && !pready) begin
      next_prdata  = prdata;
      next_pslverr = pslverr;
    end
    if (psel && !penable) begin
      next_pready = 1'b1;
      if (pwrite && !mapped(paddr)) begin
        next_pslverr = 1'b1;
      end
    end
    next_irq = |({err, boot_load_complete} & irq_mask);
  end

  // Arbitration: each loss retries until sixteen in a row, then abort.
  always_comb begin
    next_arb_state = arb_state;
    next_arb_count = arb_count;
    next_arb_retry = 1'b0;
    next_arb_abort = 1'b0;
    case (arb_state)
      GPSMS_ARB_IDLE: begin
        if (ev_arb_lost) begin
          next_arb_count = 5'h01;
          next_arb_retry = 1'b1; // [R08]
          next_arb_state = GPSMS_ARB_RETRY;
        end
      end
      GPSMS_ARB_RETRY: begin
        if (ev_arb_won) begin
          next_arb_count = 5'h00;
          next_arb_state = GPSMS_ARB_IDLE;
        end else if (ev_arb_lost) begin
          if (arb_count == `GPSMS_ARB_LIMIT - 5'h01) begin
            next_arb_abort = 1'b1; // [R09]
            next_arb_count = 5'h00;
            next_arb_state = GPSMS_ARB_IDLE;
          end else begin
            next_arb_count = arb_count + 5'h01;
            next_arb_retry = 1'b1; // [R08]
          end
        end
      end
      default: begin
        next_arb_state = GPSMS_ARB_IDLE;
        next_arb_count = 5'h00;
      end
    endcase
  end

  // Pin synchroniser and pin configuration state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync1            <= `GPSMS_PIN_LEVEL_RESET;
      pin_sync2            <= `GPSMS_PIN_LEVEL_RESET;
      pin_level_field      <= `GPSMS_PIN_LEVEL_RESET;
      pin_alternate_select <= `GPSMS_PIN_LEVEL_RESET;
      pin_direction_select <= `GPSMS_PIN_LEVEL_RESET;
      pin_out_q            <= `GPSMS_PIN_LEVEL_RESET;
      pin_oe_q             <= `GPSMS_PIN_LEVEL_RESET;
    end else if (clk_en) begin
      pin_sync1            <= pin_in;
      pin_sync2            <= pin_sync1;
      pin_level_field      <= next_pin_level_field;
      pin_alternate_select <= next_pin_alternate_select;
      pin_direction_select <= next_pin_direction_select;
      pin_out_q            <= next_pin_out;
      pin_oe_q             <= next_pin_oe;
    end
  end

  // Status flags, interrupt mask and the interrupt line.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_load_complete   <= 1'b0;
      err                  <= `GPSMS_ERROR_RESET;
      irq_mask             <= `GPSMS_MASK_RESET;
      irq                  <= 1'b0;
    end else if (clk_en) begin
      boot_load_complete   <= next_boot_load_complete;
      err                  <= next_err;
      irq_mask             <= next_irq_mask;
      irq                  <= next_irq;
    end
  end

  // Bus response; an event that arrives while clk_en is low is lost, not queued.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata               <= 32'h0000_0000;
      pready               <= 1'b0;
      pslverr              <= 1'b0;
    end else if (clk_en) begin
      prdata               <= next_prdata;
      pready               <= next_pready;
      pslverr              <= next_pslverr;
    end
  end

  // Arbitration tracker.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_state            <= GPSMS_ARB_IDLE;
      arb_count            <= 5'h00;
      arb_retry            <= 1'b0;
      arb_abort            <= 1'b0;
    end else if (clk_en) begin
      arb_state            <= next_arb_state;
      arb_count            <= next_arb_count;
      arb_retry            <= next_arb_retry;
      arb_abort            <= next_arb_abort;
    end
  end

  assign pin_out = pin_out_q;
  assign pin_oe  = pin_oe_q;
endmodule

/* bench/gpsms_checker.sv */
`timescale 1ns/100ps
module gpsms_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic [6:0]  slave_bus_address,
  input wire logic [6:0]  master_bus_address,
  input wire logic        ev_arb_lost,
  input wire logic        ev_arb_won,
  input wire logic        arb_retry,
  input wire logic        arb_abort
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [4:0] lost_cnt;
  logic [4:0] next_lost_cnt;
  logic       rd_ok;
  assign rd_ok = psel && penable && pready && !pwrite;
  always_comb begin
    next_lost_cnt = lost_cnt;
    if (ev_arb_won)
      next_lost_cnt = 5'h00;
    else if (ev_arb_lost)
      next_lost_cnt = (lost_cnt == 5'h0F) ? 5'h00 : lost_cnt + 5'h01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      lost_cnt <= 5'h00;
    else
      lost_cnt <= next_lost_cnt;
  end
  ready_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("access phase not one cycle");
  retry_after_loss_a: assert property (
    ev_arb_lost && lost_cnt != 5'h0F |=> arb_retry) else $error("no retry");
  abort_on_sixteenth_a: assert property (
    ev_arb_lost && lost_cnt == 5'h0F |=> arb_abort && !arb_retry) else $error("no abort");
  abort_cause_a: assert property (
    arb_abort |-> $past(ev_arb_lost) && $past(lost_cnt) == 5'h0F) else $error("early abort");
  data_reserved_a: assert property (
    rd_ok && paddr == 12'h340 |-> prdata[31:16] == 16'h0000) else $error("data reserved");
  status_reserved_a: assert property (rd_ok && paddr == 12'h344 |->
    {prdata[31:30], prdata[23:16], prdata[8], prdata[0]} == 12'h000) else $error("sts rsvd");
  slave_addr_a: assert property (
    rd_ok && paddr == 12'h344 |-> prdata[7:1] == slave_bus_address) else $error("slave addr");
  master_addr_a: assert property (
    rd_ok && paddr == 12'h344 |-> prdata[15:9] == master_bus_address) else $error("mst addr");
endmodule
bind gpsms_regs gpsms_checker i_gpsms_checker (.*);

/* bench/gpsms_far_model.sv */
`timescale 1ns/100ps
module gpsms_far_model (
  input  wire logic        pclk,
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  output logic      [15:0] pin_in,
  output logic      [7:0]  ev
);
  // Pins the block does not drive show what the outside board puts on them.
  logic [15:0] ext_lvl = 16'hA5C3;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
  initial ev = 8'h00;
  task automatic pulse(input int k);
    @(posedge pclk);
    ev <= 8'h01 << k;
    @(posedge pclk);
    ev <= 8'h00;
  endtask
endmodule

/* bench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        boot_load_enable, boot_load_finish, ev_no_ack, ev_arb_lost, ev_arb_won;
  logic        ev_misplaced, ev_checksum_bad, ev_no_done_cmd, ev_unmapped, arb_retry, arb_abort;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pin_in, pin_out, pin_oe;
  logic [6:0]  slave_bus_address, master_bus_address;
  logic [7:0]  ev;
  int          bad_count, tests_run, i;
  int          evi[5] = '{6, 0, 3, 4, 5};
  int          bt[5] = '{29, 25, 27, 28, 28};
  localparam logic [31:0] ADDRS = 32'h0000A256;
  assign {boot_load_finish, ev_unmapped, ev_no_done_cmd, ev_checksum_bad, ev_misplaced,
          ev_arb_won, ev_arb_lost, ev_no_ack} = ev;
  gpsms_regs i_gpsms_regs (.*);
  gpsms_far_model i_gpsms_far_model (.*);
  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      bad_count++;
      end_sim();
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'h0, a, 32'h00000000);
    chk(nm, e, rd);
  endtask
  initial begin
    {presetn, clk_en, psel, penable, pwrite} = 5'h08;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    slave_bus_address = 7'h2B;
    master_bus_address = 7'h51;
    boot_load_enable = 1'h0;
    bad_count = 0;
    tests_run = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    repeat (4) @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    chk("pin enable", 32'h0, {16'h0, pin_oe});
    rdchk(12'h340, 32'h0000A5C3, "pin level");
    rdchk(12'h344, ADDRS, "status");
    apb(1'h0, 12'h360, 32'h00000000);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1'h1, 12'h338, 32'h0000000F);
    apb(1'h1, 12'h33C, 32'h000000FF);
    apb(1'h1, 12'h340, 32'hFFFF3CA5);
    repeat (6) @(posedge pclk);
    chk("pin enable", 32'h000000F0, {16'h0, pin_oe});
    chk("pin drive", 32'h000000A0, {16'h0, pin_out & pin_oe});
    rdchk(12'h340, 32'h0000A5A3, "pin level");
    i_gpsms_far_model.pulse(6);
    repeat (3) @(posedge pclk);
    chk("masked irq", 32'h0, {31'h0, irq});
    apb(1'h1, 12'h350, 32'h3F000000);
    for (i = 0; i < 5; i++) begin
      i_gpsms_far_model.pulse(evi[i]);
      repeat (3) @(posedge pclk);
      chk("irq", 32'h1, {31'h0, irq});
      rdchk(12'h344, ADDRS | (32'h1 << bt[i]), "flag");
      apb(1'h1, 12'h344, 32'h1 << bt[i]);
      rdchk(12'h344, ADDRS, "cleared flag");
      repeat (3) @(posedge pclk);
      chk("irq", 32'h0, {31'h0, irq});
    end
    // A win in the middle must restart the count, so no abort yet.
    for (i = 0; i < 31; i++)
      i_gpsms_far_model.pulse(i == 15 ? 2 : 1);
    rdchk(12'h344, ADDRS, "no abort");
    i_gpsms_far_model.pulse(1);
    repeat (3) @(posedge pclk);
    rdchk(12'h344, ADDRS | 32'h04000000, "abort flag");
    i_gpsms_far_model.pulse(7);
    repeat (3) @(posedge pclk);
    rdchk(12'h344, ADDRS | 32'h04000000, "load off");
    boot_load_enable <= 1'h1;
    i_gpsms_far_model.pulse(6);
    repeat (3) @(posedge pclk);
    rdchk(12'h344, ADDRS | 32'h25000000, "load error done");
    apb(1'h1, 12'h344, 32'hFFFFFFFF);
    rdchk(12'h344, ADDRS | 32'h01000000, "read only");
    clk_en <= 1'h0;
    i_gpsms_far_model.pulse(0);
    clk_en <= 1'h1;
    rdchk(12'h344, ADDRS | 32'h01000000, "frozen event");
    end_sim();
  end
endmodule
